// ==== adc_cmp_pkg.sv ====
/*
 Constants for the auxiliary converter channel select and threshold comparator bank.
 Assumes an APB slave with 32-bit data, one register per aligned word.
*/
// Notes on behaviour
// - Source register bit 6 includes the supply-voltage channel in the round robin when set.
// - Source register bit 4 includes the chip temperature channel when set.
// - Source register bits 2, 1 and 0 include pins C, B and A when set.
// - Control register bits 3 down to 0 enable comparators 4 down to 1.
// - Status bits 11 down to 8 read 1 when comparator 4 down to 1 has seen its condition.
// - Direction bit 12 selects below the threshold when 0 and greater or equal when 1.
// - Source field 15:13 selects 1 pin A, 2 pin B, 3 pin C, 5 temperature, 7 supply; 4 and 6 reserved, 0 reserved except on comparator 4.
// - Threshold field 11:0 is a 12-bit unsigned value compared directly with result data.
// - Comparator 2 has its own register with the same fields as comparator 1.
// - Each enabled comparator sets its interrupt status bit when its flag rises; irq is raised only if its interrupt enable bit is also set.
// - For comparator 4 only, source code 0 selects the backup battery voltage.
// - Results are 12-bit data paired with a 4-bit source code.
package adc_cmp_pkg;

	// ----------------------------------------
	// Register word indices and address width
	// ----------------------------------------
	localparam logic [15:0] IDX_CHANNEL_SELECT = 16'h402F;
	localparam logic [15:0] IDX_CMP_ENABLE     = 16'h4030;
	localparam logic [15:0] IDX_CMP_ONE        = 16'h4031;
	localparam logic [15:0] IDX_CMP_TWO        = 16'h4032;
	localparam logic [15:0] IDX_CMP_THREE      = 16'h4033;
	localparam logic [15:0] IDX_CMP_FOUR       = 16'h4034;
	localparam logic [15:0] IDX_IRQ_STATUS     = 16'h4040;
	localparam logic [15:0] IDX_IRQ_ENABLE     = 16'h4041;
	localparam logic [15:0] IDX_IRQ_CLEAR      = 16'h4042;
	localparam int          ADDR_W             = 18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SEL_SUPPLY_BIT = 6;
	localparam int SEL_TEMP_BIT   = 4;
	localparam int SEL_PIN_C_BIT  = 2;
	localparam int SEL_PIN_B_BIT  = 1;
	localparam int SEL_PIN_A_BIT  = 0;
	localparam int FLAG_LSB       = 8;
	localparam int CFG_SRC_MSB    = 15;
	localparam int CFG_SRC_LSB    = 13;
	localparam int CFG_DIR_BIT    = 12;
	localparam int CFG_THR_MSB    = 11;
	localparam int NUM_CMP        = 4;

	// ----------------------------------------
	// Masks and reset values
	// ----------------------------------------
	localparam logic [15:0] SEL_MASK      = 16'h0057;
	localparam logic [15:0] SEL_RESET     = 16'h0000;
	localparam logic [3:0]  ENABLE_RESET  = 4'h0;
	localparam logic [15:0] CFG_RESET     = 16'h0000;

	// ----------------------------------------
	// Result source codes (4-bit)
	// ----------------------------------------
	localparam logic [3:0] SRC_BACKUP = 4'h0;
	localparam logic [3:0] SRC_PIN_A  = 4'h1;
	localparam logic [3:0] SRC_PIN_B  = 4'h2;
	localparam logic [3:0] SRC_PIN_C  = 4'h3;
	localparam logic [3:0] SRC_TEMP   = 4'h5;
	localparam logic [3:0] SRC_SUPPLY = 4'h7;

endpackage : adc_cmp_pkg

// ==== threshold_cmp.sv ====
/*
 One threshold comparator with a detect flag updated on each result of its source.
 Assumes result strobes are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module threshold_cmp
	import adc_cmp_pkg::*;
#(
	parameter bit BACKUP_OK = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        on,
	input  wire logic [2:0]  input_code,
	input  wire logic        direction,
	input  wire logic [11:0] level,
	input  wire logic        result_valid,
	input  wire logic [3:0]  result_source,
	input  wire logic [11:0] result_data,
	output logic             hit
);

	logic source_ok;
	logic match;

	// ----------------------------------------
	// Source match and condition
	// ----------------------------------------
	always_comb begin
		source_ok = (result_source == {1'b0, input_code});
		if (input_code == 3'h4 || input_code == 3'h6)
			source_ok = 1'b0;
		if (input_code == 3'h0)
			source_ok = BACKUP_OK && (result_source == SRC_BACKUP);
		match = direction ? (result_data >= level) : (result_data < level);
	end

	// ----------------------------------------
	// Evaluate on each new result of own source
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hit <= 1'b0;
		else if (!on)
			hit <= 1'b0;
		else if (result_valid && source_ok)
			hit <= match;
	end

	AST_HIT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
		on && $past(on) && result_valid && source_ok |=> hit == $past(match))
		else $error("comparator flag did not follow the result");
	AST_OFF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		!on |=> !hit)
		else $error("disabled comparator flag set");
	AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
		(input_code == 3'h4 || input_code == 3'h6) && !hit |=> !hit)
		else $error("reserved source set a flag");

endmodule : threshold_cmp
`default_nettype wire

// ==== adc_input_select_compare.sv ====
/*
 Channel select and four-comparator bank for the auxiliary converter, APB slave.
 Assumes results arrive as a one-cycle valid strobe with 4-bit source and 12-bit data on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_compare
	import adc_cmp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        result_valid,
	input  wire logic [3:0]  result_source,
	input  wire logic [11:0] result_data,
	output logic             supply_channel_include,
	output logic             temp_channel_include,
	output logic             pin_c_channel_include,
	output logic             pin_b_channel_include,
	output logic             pin_a_channel_include,
	output logic             irq
);

	logic [15:0]         channel_select;
	logic [NUM_CMP-1:0]  cmp_on;
	logic [15:0]         cmp_cfg [NUM_CMP];
	logic [NUM_CMP-1:0]  cmp_flag;
	logic [NUM_CMP-1:0]  flag_prev;
	logic [NUM_CMP-1:0]  irq_status;
	logic [NUM_CMP-1:0]  irq_enable;
	logic [15:0]         word_index;
	logic                setup;
	logic                wr;
	logic                mapped;
	logic [NUM_CMP-1:0]  clear_bits;
	logic [31:0]         next_prdata;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign word_index = paddr[ADDR_W-1:2];
	assign setup      = psel && !penable;
	assign wr         = psel && penable && pready && pwrite && !pslverr;

	always_comb begin
		mapped = 1'b1;
		if (paddr[1:0] != 2'h0 || paddr[31:ADDR_W] != '0)
			mapped = 1'b0;
		else if (word_index == IDX_CHANNEL_SELECT)
			mapped = 1'b1;
		else if (word_index >= IDX_CMP_ENABLE && word_index <= IDX_CMP_FOUR)
			mapped = 1'b1;
		else if (word_index >= IDX_IRQ_STATUS && word_index <= IDX_IRQ_CLEAR)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (!mapped)
			next_prdata = 32'h0000_0000;
		else if (word_index == IDX_CHANNEL_SELECT)
			next_prdata = {16'h0000, channel_select};
		else if (word_index == IDX_CMP_ENABLE)
			next_prdata = {20'h00000, cmp_flag, 4'h0, cmp_on};
		else if (word_index == IDX_CMP_ONE)
			next_prdata = {16'h0000, cmp_cfg[0]};
		else if (word_index == IDX_CMP_TWO)
			next_prdata = {16'h0000, cmp_cfg[1]};
		else if (word_index == IDX_CMP_THREE)
			next_prdata = {16'h0000, cmp_cfg[2]};
		else if (word_index == IDX_CMP_FOUR)
			next_prdata = {16'h0000, cmp_cfg[3]};
		else if (word_index == IDX_IRQ_STATUS)
			next_prdata = {28'h0000000, irq_status};
		else if (word_index == IDX_IRQ_ENABLE)
			next_prdata = {28'h0000000, irq_enable};
		else
			next_prdata = 32'h0000_0000;
	end

	// ----------------------------------------
	// Bus response: no wait states
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
				prdata <= next_prdata;
		end
	end

	// ----------------------------------------
	// Channel select and enable registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_select <= SEL_RESET;
			cmp_on         <= ENABLE_RESET;
			irq_enable     <= ENABLE_RESET;
		end else if (wr) begin
			if (word_index == IDX_CHANNEL_SELECT)
				channel_select <= pwdata[15:0] & SEL_MASK;
			else if (word_index == IDX_CMP_ENABLE)
				cmp_on <= pwdata[NUM_CMP-1:0];
			else if (word_index == IDX_IRQ_ENABLE)
				irq_enable <= pwdata[NUM_CMP-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_channel_include <= 1'b0;
			temp_channel_include   <= 1'b0;
			pin_c_channel_include  <= 1'b0;
			pin_b_channel_include  <= 1'b0;
			pin_a_channel_include  <= 1'b0;
		end else begin
			supply_channel_include <= channel_select[SEL_SUPPLY_BIT];
			temp_channel_include   <= channel_select[SEL_TEMP_BIT];
			pin_c_channel_include  <= channel_select[SEL_PIN_C_BIT];
			pin_b_channel_include  <= channel_select[SEL_PIN_B_BIT];
			pin_a_channel_include  <= channel_select[SEL_PIN_A_BIT];
		end
	end

	// ----------------------------------------
	// Comparator configuration
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CMP; i++)
				cmp_cfg[i] <= CFG_RESET;
		end else if (wr && word_index >= IDX_CMP_ONE && word_index <= IDX_CMP_FOUR) begin
			cmp_cfg[2'(word_index - IDX_CMP_ONE)] <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Comparator bank
	// ----------------------------------------
	for (genvar g = 0; g < NUM_CMP; g++) begin : gen_cmp
		threshold_cmp #(
			.BACKUP_OK (g == NUM_CMP - 1)
		) u_cmp (
			.pclk          (pclk),
			.presetn       (presetn),
			.on            (cmp_on[g]),
			.input_code    (cmp_cfg[g][CFG_SRC_MSB:CFG_SRC_LSB]),
			.direction     (cmp_cfg[g][CFG_DIR_BIT]),
			.level         (cmp_cfg[g][CFG_THR_MSB:0]),
			.result_valid  (result_valid),
			.result_source (result_source),
			.result_data   (result_data),
			.hit           (cmp_flag[g])
		);
	end

	// ----------------------------------------
	// Interrupt status, set wins over clear
	// ----------------------------------------
	assign clear_bits = (wr && word_index == IDX_IRQ_CLEAR) ? pwdata[NUM_CMP-1:0] : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_prev  <= 4'h0;
			irq_status <= 4'h0;
			irq        <= 1'b0;
		end else begin
			flag_prev  <= cmp_flag;
			irq_status <= (irq_status & ~clear_bits) | (cmp_flag & ~flag_prev);
			irq        <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_SUPPLY_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		##1 supply_channel_include == $past(channel_select[SEL_SUPPLY_BIT]))
		else $error("supply include does not track select");
	AST_TEMP_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		wr && word_index == IDX_CHANNEL_SELECT |-> ##2 temp_channel_include == $past(pwdata[4], 2))
		else $error("temperature include wrong after write");
	AST_PIN_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		wr && word_index == IDX_CHANNEL_SELECT |-> ##2 pin_a_channel_include == $past(pwdata[0], 2))
		else $error("pin include wrong after write");
	AST_OFF_NO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		!cmp_on[0] ##1 !cmp_on[0] |-> !cmp_flag[0])
		else $error("disabled comparator shows a flag");
	AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && mapped && word_index == IDX_CMP_ENABLE |=> prdata[11:8] == $past(cmp_flag))
		else $error("status bits misread");
	AST_GE_DETECT: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_on[1] && $past(cmp_on[1]) && result_valid && cmp_cfg[1][15:13] == 3'h1
		&& result_source == SRC_PIN_A && cmp_cfg[1][12] && result_data >= cmp_cfg[1][11:0]
		|=> cmp_flag[1])
		else $error("greater-or-equal detect missed");
	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_flag[0] && !flag_prev[0] && irq_enable[0] |-> ##2 irq)
		else $error("enabled event did not raise the interrupt");
	AST_BACKUP: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_on[3] && $past(cmp_on[3]) && result_valid && cmp_cfg[3][15:13] == 3'h0
		&& result_source == SRC_BACKUP && !cmp_cfg[3][12] && result_data < cmp_cfg[3][11:0]
		|=> cmp_flag[3])
		else $error("backup source not detected");

endmodule : adc_input_select_compare
`default_nettype wire

// ==== adc_input_select_compare_tb.sv ====
/*
 Self-checking bench for the converter channel select and comparator bank.
 Assumes a zero-wait APB slave and one-cycle result strobes on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_compare_tb
	import adc_cmp_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        result_valid;
	logic [3:0]  result_source;
	logic [11:0] result_data;
	logic        sup;
	logic        tmp;
	logic        pc;
	logic        pb;
	logic        pa;
	logic        irq;
	int          bad_count;
	int          check_count;
	logic [32:0] exp_q[$];
	logic [15:0] idxs [9] = '{IDX_CHANNEL_SELECT, IDX_CMP_ENABLE, IDX_CMP_ONE, IDX_CMP_TWO,
		IDX_CMP_THREE, IDX_CMP_FOUR, IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR};

	adc_input_select_compare dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.result_valid(result_valid), .result_source(result_source), .result_data(result_data),
		.supply_channel_include(sup), .temp_channel_include(tmp), .pin_c_channel_include(pc),
		.pin_b_channel_include(pb), .pin_a_channel_include(pa), .irq(irq)
	);

	always #10 pclk = ~pclk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] ba(input logic [15:0] idx);
		return {14'h0, idx, 2'b00};
	endfunction : ba

	task automatic chk(input string name, input logic [32:0] e, input logic [32:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) chk("pready", 1'b1, pready);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [31:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic res(input logic [3:0] s, input logic [11:0] d);
		@(posedge pclk);
		result_valid  <= 1'b1;
		result_source <= s;
		result_data   <= d;
		@(posedge pclk);
		result_valid  <= 1'b0;
		result_source <= 4'($urandom);
		result_data   <= 12'($urandom);
		repeat (2) @(posedge pclk);
	endtask : res

	task automatic settle();
		repeat (3) @(negedge pclk);
	endtask : settle

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// Read monitor
	// ----------------------------------------
	always @(posedge pclk) begin : mon
		logic [32:0] e;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1FFFFFFFF;
			chk("read", e, {pslverr, prdata});
		end
	end

	initial begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		$display("watchdog expired");
		tally_and_finish();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [15:0] v;
		logic [11:0] thr;
		logic [11:0] dat;
		logic [2:0]  code;
		logic        on;
		logic        dir;
		logic        hit;
		pclk          = 1'b0;
		presetn       = 1'b0;
		psel          = 1'b0;
		penable       = 1'b0;
		pwrite        = 1'b0;
		paddr         = 32'h0;
		pwdata        = 32'h0;
		result_valid  = 1'b0;
		result_source = 4'h0;
		result_data   = 12'h000;
		bad_count     = 0;
		check_count   = 0;
		void'($urandom(87856));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 9; k++) rd(ba(idxs[k]), 33'h0);
		chk("include", 5'h00, {sup, tmp, pc, pb, pa});
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 16'hFFFF : 16'($urandom);
			apb(1'b1, ba(IDX_CHANNEL_SELECT), {16'h0, v});
			rd(ba(IDX_CHANNEL_SELECT), {17'h0, v & SEL_MASK});
			chk("include", {v[6], v[4], v[2], v[1], v[0]}, {sup, tmp, pc, pb, pa});
		end
		$display("test select done");
		rd(32'h0, {1'b1, 32'h0});
		rd(ba(IDX_CMP_ENABLE) + 32'h1, {1'b1, 32'h0});
		$display("test unmapped done");
		for (int i = 0; i < NUM_CMP; i++) begin
			for (int c = 0; c < 8; c++) begin
				for (int g = 0; g < 2; g++) begin
					code = 3'(c);
					dir  = (g == 1);
					thr  = 12'(1 + $urandom % 4095);
					dat  = thr - 12'($urandom % 2);
					on   = ($urandom % 4) != 0;
					hit  = on && (code inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7} ||
						(i == 3 && code == 3'h0)) && (dir ? dat >= thr : dat < thr);
					apb(1'b1, ba(IDX_CMP_ENABLE), 32'h0);
					apb(1'b1, ba(IDX_CMP_ONE + 16'(i)), {16'h0, code, dir, thr});
					rd(ba(IDX_CMP_ONE + 16'(i)), {17'h0, code, dir, thr});
					apb(1'b1, ba(IDX_CMP_ENABLE), 32'(on) << i);
					res({1'b0, code}, dat);
					rd(ba(IDX_CMP_ENABLE), 33'((32'(hit) << (FLAG_LSB + i)) | (32'(on) << i)));
				end
			end
		end
		$display("test comparators done");
		apb(1'b1, ba(IDX_IRQ_CLEAR), 32'hF);
		apb(1'b1, ba(IDX_IRQ_ENABLE), 32'h1);
		rd(ba(IDX_IRQ_ENABLE), 33'h1);
		apb(1'b1, ba(IDX_CMP_ENABLE), 32'h0);
		apb(1'b1, ba(IDX_CMP_ONE), {16'h0, 3'h1, 1'b1, 12'h064});
		apb(1'b1, ba(IDX_CMP_ENABLE), 32'h1);
		rd(ba(IDX_IRQ_STATUS), 33'h0);
		chk("irq", 1'b0, irq);
		res(SRC_PIN_A, 12'h0C8);
		settle();
		chk("irq", 1'b1, irq);
		rd(ba(IDX_IRQ_STATUS), 33'h1);
		rd(ba(IDX_CMP_ENABLE), 33'h101);
		apb(1'b1, ba(IDX_IRQ_ENABLE), 32'h0);
		settle();
		chk("irq", 1'b0, irq);
		apb(1'b1, ba(IDX_IRQ_ENABLE), 32'h1);
		settle();
		chk("irq", 1'b1, irq);
		apb(1'b1, ba(IDX_IRQ_CLEAR), 32'h1);
		settle();
		chk("irq", 1'b0, irq);
		rd(ba(IDX_IRQ_STATUS), 33'h0);
		rd(ba(IDX_IRQ_CLEAR), 33'h0);
		apb(1'b1, ba(IDX_CMP_ENABLE), 32'h0);
		rd(ba(IDX_CMP_ENABLE), 33'h0);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule : adc_input_select_compare_tb
`default_nettype wire
